// file: design/cmbx_pkg.sv
package cmbx_pkg;

  // ==========================================================================
  // Page map
  // ==========================================================================
  localparam logic [7:0] CMBX_MSG_PAGE      = 8'h9f;
  localparam logic [7:0] CMBX_UPPER_BASE    = 8'h80;
  localparam logic [7:0] CMBX_CODE_HI       = 8'h80;
  localparam logic [7:0] CMBX_CODE_LO       = 8'h81;
  localparam logic [6:0] CMBX_IDX_EXT_HI    = 7'h02;
  localparam logic [6:0] CMBX_IDX_EXT_LO    = 7'h03;
  localparam logic [6:0] CMBX_IDX_LOC_LEN   = 7'h04;
  localparam logic [6:0] CMBX_IDX_CHK       = 7'h05;
  localparam logic [6:0] CMBX_IDX_RPL_LEN   = 7'h06;
  localparam logic [6:0] CMBX_IDX_RPL_CHK   = 7'h07;
  localparam logic [6:0] CMBX_IDX_LPL       = 7'h08;
  localparam logic [7:0] CMBX_OFS_RPL_LEN   = 8'h86;
  localparam logic [7:0] CMBX_OFS_RPL_CHK   = 8'h87;
  localparam logic [7:0] CMBX_OFS_LPL       = 8'h88;

  // ==========================================================================
  // Lengths and reply length encoding
  // ==========================================================================
  localparam logic [7:0] CMBX_LPL_MAX       = 8'h78;
  localparam logic [7:0] CMBX_RPL_EPL_MIN   = 8'hf0;

  // ==========================================================================
  // Execution status values and completion flag positions
  // ==========================================================================
  localparam logic [7:0] CMBX_STAT_IDLE     = 8'h00;
  localparam logic [7:0] CMBX_STAT_BUSY     = 8'h81;
  localparam logic [7:0] CMBX_STAT_OK       = 8'h01;
  localparam logic [7:0] CMBX_STAT_CHK_ERR  = 8'h45;
  localparam logic [7:0] CMBX_STAT_FAIL     = 8'h46;
  localparam logic [7:0] CMBX_STAT_LEN_ERR  = 8'h47;
  localparam int         CMBX_FLAG_BYTE     = 8;
  localparam int         CMBX_FLAG_BIT_I0   = 7;
  localparam int         CMBX_FLAG_BIT_I1   = 6;
  localparam int         CMBX_STAT_BYTE_I0  = 37;
  localparam int         CMBX_STAT_BYTE_I1  = 38;

  typedef enum logic [2:0] {
    CMBX_IDLE  = 3'b000,
    CMBX_SUM   = 3'b001,
    CMBX_CHECK = 3'b010,
    CMBX_EXEC  = 3'b011,
    CMBX_RSUM  = 3'b100,
    CMBX_WLEN  = 3'b101,
    CMBX_WCHK  = 3'b110,
    CMBX_DONE  = 3'b111
  } cmbx_state_t;

endpackage : cmbx_pkg

// file: design/cmbx_sum.sv
`timescale 1ns/1ps

// Running modulo-256 byte sum, shared by the command and reply checks.
module cmbx_sum #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             add_en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] sum
);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sum <= '0;
    end else if (clr) begin
      sum <= '0;
    end else if (add_en) begin
      sum <= sum + din;
    end
  end

endmodule : cmbx_sum

// file: design/cmbx_mailbox.sv
`timescale 1ns/1ps

// Contract
// - Reply length: 0-120 local bytes, 240-255 extended pages, rest reserved.
// - Local reply check is inverted sum of reply bytes; zero without a body.
// - Extended-only reply check is inverted sum of all used extended bytes.
// - Mixed replies take length and check from the executed command.
// - Command checksum covers length fields, never the reply header bytes.
// - Local payload holds arguments and replies; replies may overwrite them.
// - A write ending at or including the code low byte starts execution.
// - Execution status byte is kept current while a command runs.
// - Completion flag is set when a command finishes.
// - Trigger mode bit selects which write event starts processing.
// - Mode 0: STOP ending a one or two byte write at byte 129.
// - Mode 1: STOP of any write whose span includes byte 129.
// - Body may sit in local, extended or both areas per command.
// - Extended payload gets no general validity check here.
// - Checksum is inverted sum of bytes 128 to 136+len-1 less 133-135.
// - Command header bytes are left untouched by the reply.
module cmbx_mailbox
  import cmbx_pkg::*;
#(
  parameter logic TRIGGER_MODE = 1'b0
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  cur_page,
  input  wire logic        acc_wr,
  input  wire logic [7:0]  acc_addr,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic        acc_stop,
  input  wire logic [7:0]  rd_addr,
  output logic      [7:0]  rd_data,
  output logic             cmd_start,
  output logic      [15:0] cmd_code,
  output logic      [15:0] cmd_ext_len,
  output logic      [7:0]  cmd_loc_len,
  output logic             cmd_chk_ok,
  input  wire logic        rep_wr,
  input  wire logic [7:0]  rep_addr,
  input  wire logic [7:0]  rep_wdata,
  input  wire logic        rep_done,
  input  wire logic        rep_fail,
  input  wire logic [7:0]  rep_len,
  input  wire logic        rep_span,
  input  wire logic [7:0]  rep_span_chk,
  input  wire logic [7:0]  rep_ext_sum,
  input  wire logic        cmp_clr,
  output logic      [7:0]  exec_status,
  output logic             cmd_complete
);

  import cmbx_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    cmbx_state_t st;
    logic [6:0]  idx;
    logic [6:0]  lim;
    logic [1:0]  wcnt;
    logic        hit_lo;
    logic        last_lo;
    logic        cmd_start;
    logic [15:0] cmd_code;
    logic [15:0] cmd_ext_len;
    logic [7:0]  cmd_loc_len;
    logic        cmd_chk_ok;
    logic [7:0]  rlen;
    logic [7:0]  rchk;
    logic        rfail;
    logic [7:0]  status;
    logic        complete;
    logic [7:0]  rd_data;
  } cmbx_regs_t;

  cmbx_regs_t r;
  cmbx_regs_t next_r;

  // The page bytes 128-255 live in one local array.
  logic [7:0] page_mem [128];

  logic        mem_we;
  logic [6:0]  mem_idx;
  logic [7:0]  mem_wdata;
  logic        sum_clr;
  logic        sum_add;
  logic [7:0]  sum;
  logic        host_wr;
  logic        trigger;
  logic [7:0]  cur_byte;

  assign cur_byte = page_mem[r.idx];
  assign host_wr  = acc_wr && (cur_page == CMBX_MSG_PAGE)
                    && acc_addr[7];

  cmbx_sum #(
    .WIDTH (8)
  ) u_sum (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clr     (sum_clr),
    .add_en  (sum_add),
    .din     (cur_byte),
    .sum     (sum)
  );

  // ==========================================================================
  // Trigger detection across one write transaction
  // ==========================================================================
  always_comb begin
    if (TRIGGER_MODE) begin
      trigger = acc_stop && r.hit_lo && (r.wcnt != 2'd0);
    end else begin
      trigger = acc_stop && r.last_lo && (r.wcnt != 2'd0)
                && (r.wcnt <= 2'd2);
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_r           = r;
    next_r.cmd_start = 1'b0;
    mem_we           = 1'b0;
    mem_idx          = acc_addr[6:0];
    mem_wdata        = acc_wdata;
    sum_clr          = 1'b0;
    sum_add          = 1'b0;

    next_r.rd_data = (cur_page == CMBX_MSG_PAGE && rd_addr[7])
                     ? page_mem[rd_addr[6:0]] : 8'h00;

    // Writes on other pages never count toward a trigger.
    if (acc_stop) begin
      next_r.wcnt    = 2'd0;
      next_r.hit_lo  = 1'b0;
      next_r.last_lo = 1'b0;
    end else if (host_wr) begin
      if (r.wcnt != 2'd3) begin
        next_r.wcnt = r.wcnt + 2'd1;
      end
      next_r.hit_lo  = r.hit_lo || (acc_addr == CMBX_CODE_LO);
      next_r.last_lo = (acc_addr == CMBX_CODE_LO);
    end

    // Host bytes land unless the executor or a reply header write owns the write port this cycle.
    if (host_wr && !(rep_wr && r.st == CMBX_EXEC)) begin
      mem_we = 1'b1;
    end

    if (cmp_clr) begin
      next_r.complete = 1'b0;
    end

    unique case (r.st)
      CMBX_IDLE: begin
        // A new code during execution is not acted on.
        if (trigger && (cur_page == CMBX_MSG_PAGE)) begin
          next_r.cmd_code    = {page_mem[7'h00], page_mem[7'h01]};
          next_r.cmd_ext_len = {page_mem[CMBX_IDX_EXT_HI],
                                page_mem[CMBX_IDX_EXT_LO]};
          next_r.cmd_loc_len = page_mem[CMBX_IDX_LOC_LEN];
          next_r.lim = (page_mem[CMBX_IDX_LOC_LEN] > CMBX_LPL_MAX)
                       ? 7'(CMBX_LPL_MAX + 8'd7)
                       : 7'(page_mem[CMBX_IDX_LOC_LEN] + 8'd7);
          next_r.idx    = 7'd0;
          next_r.status = CMBX_STAT_BUSY;
          sum_clr       = 1'b1;
          next_r.st     = CMBX_SUM;
        end
      end
      CMBX_SUM: begin
        // Length fields are summed; the stored checksum and reply header not.
        sum_add = (r.idx < CMBX_IDX_CHK) || (r.idx >= CMBX_IDX_LPL);
        next_r.idx = r.idx + 7'd1;
        if (r.idx == r.lim) begin
          next_r.st = CMBX_CHECK;
        end
      end
      CMBX_CHECK: begin
        next_r.cmd_chk_ok = ((~sum) == page_mem[CMBX_IDX_CHK]);
        next_r.cmd_start  = 1'b1;
        next_r.st         = CMBX_EXEC;
      end
      CMBX_EXEC: begin
        // Extended payload is validated only by the command executor.
        if (rep_wr && rep_addr >= CMBX_OFS_LPL) begin
          mem_we    = 1'b1;
          mem_idx   = rep_addr[6:0];
          mem_wdata = rep_wdata;
        end
        if (rep_done) begin
          next_r.rlen  = rep_len;
          next_r.rfail = rep_fail;
          next_r.idx   = CMBX_IDX_LPL;
          sum_clr      = 1'b1;
          if (rep_span) begin
            next_r.rchk = rep_span_chk;
            next_r.st   = CMBX_WLEN;
          end else if (rep_len >= CMBX_RPL_EPL_MIN) begin
            next_r.rchk = ~rep_ext_sum;
            next_r.st   = CMBX_WLEN;
          end else if (rep_len > CMBX_LPL_MAX) begin
            next_r.rchk  = 8'h00;
            next_r.rfail = 1'b1;
            next_r.st    = CMBX_WLEN;
          end else if (rep_len == 8'h00) begin
            next_r.rchk = 8'h00;
            next_r.st   = CMBX_WLEN;
          end else begin
            next_r.lim = 7'(rep_len + 8'd7);
            next_r.st  = CMBX_RSUM;
          end
        end
      end
      CMBX_RSUM: begin
        sum_add    = 1'b1;
        next_r.idx = r.idx + 7'd1;
        if (r.idx == r.lim) begin
          next_r.st = CMBX_DONE;
        end
      end
      CMBX_DONE: begin
        next_r.rchk = ~sum;
        next_r.st   = CMBX_WLEN;
      end
      CMBX_WLEN: begin
        // Only the two reply header bytes are rewritten.
        mem_we    = 1'b1;
        mem_idx   = CMBX_IDX_RPL_LEN;
        mem_wdata = r.rlen;
        next_r.st = CMBX_WCHK;
      end
      CMBX_WCHK: begin
        mem_we          = 1'b1;
        mem_idx         = CMBX_IDX_RPL_CHK;
        mem_wdata       = r.rchk;
        next_r.complete = 1'b1;
        next_r.st       = CMBX_IDLE;
        if (r.rlen > CMBX_LPL_MAX && r.rlen < CMBX_RPL_EPL_MIN) begin
          next_r.status = CMBX_STAT_LEN_ERR;
        end else if (!r.cmd_chk_ok) begin
          next_r.status = CMBX_STAT_CHK_ERR;
        end else if (r.rfail) begin
          next_r.status = CMBX_STAT_FAIL;
        end else begin
          next_r.status = CMBX_STAT_OK;
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.st     <= CMBX_IDLE;
      r.status <= CMBX_STAT_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // The array has no reset; the host presets what it relies on.
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      page_mem[mem_idx] <= mem_wdata;
    end
  end

  assign rd_data      = r.rd_data;
  assign cmd_start    = r.cmd_start;
  assign cmd_code     = r.cmd_code;
  assign cmd_ext_len  = r.cmd_ext_len;
  assign cmd_loc_len  = r.cmd_loc_len;
  assign cmd_chk_ok   = r.cmd_chk_ok;
  assign exec_status  = r.status;
  assign cmd_complete = r.complete;

endmodule : cmbx_mailbox

// file: tb/cmbx_mailbox_chk.sv
`timescale 1ns/1ps
module cmbx_mailbox_chk (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] cur_page,
  input wire logic       acc_stop,
  input wire logic [7:0] rd_data,
  input wire logic       cmd_start,
  input wire logic       cmd_chk_ok,
  input wire logic       rep_done,
  input wire logic       cmp_clr,
  input wire logic [7:0] exec_status,
  input wire logic       cmd_complete
);
  import cmbx_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence busy_onset;
    exec_status == CMBX_STAT_BUSY && $past(exec_status) != CMBX_STAT_BUSY;
  endsequence
  a_start_pulse: assert property (
    cmd_start |=> !cmd_start) else $error("start pulse too long");
  a_busy_cause: assert property (
    busy_onset |-> ($past(acc_stop) && $past(cur_page) == CMBX_MSG_PAGE) ||
      ($past(acc_stop, 2) && $past(cur_page, 2) == CMBX_MSG_PAGE))
    else $error("busy without a trigger on the message page");
  a_start_busy: assert property (
    cmd_start |-> exec_status == CMBX_STAT_BUSY) else $error("not busy");
  a_start_time: assert property (
    busy_onset |-> ##[8:135] cmd_start) else $error("start missing");
  a_done_time: assert property (
    rep_done |-> ##[1:130] cmd_complete) else $error("completion missing");
  a_flag_hold: assert property (
    cmd_complete && !cmp_clr |=> cmd_complete) else $error("flag dropped");
  a_done_status: assert property (
    $rose(cmd_complete) |-> exec_status != CMBX_STAT_BUSY)
    else $error("still busy at completion");
  a_rd_offpage: assert property (
    cur_page != CMBX_MSG_PAGE |=> rd_data == 8'h00)
    else $error("read data off the message page");
  c_start: cover property (cmd_start);
  c_bad_chk: cover property (cmd_start && !cmd_chk_ok);
  c_done: cover property ($rose(cmd_complete));
endmodule : cmbx_mailbox_chk

// file: tb/cmbx_host.sv
`timescale 1ns/1ps
module cmbx_host (
  input  wire logic sys_clk,
  output logic [7:0] cur_page,
  output logic       acc_wr,
  output logic [7:0] acc_addr,
  output logic [7:0] acc_wdata,
  output logic       acc_stop
);
  // Longer writes are cut here, as a real host splits them into accesses.
  localparam int MAX_BYTES = 16;
  initial begin
    cur_page = 8'h00;
    acc_wr = 1'b0;
    acc_addr = 8'h00;
    acc_wdata = 8'h00;
    acc_stop = 1'b0;
  end
  // One transaction; the offset wraps inside the upper half of the page.
  task automatic wr(input logic [7:0] pg, input logic [7:0] a,
                    input logic [7:0] b [$]);
    @(posedge sys_clk);
    cur_page <= pg;
    for (int i = 0; i < b.size() && i < MAX_BYTES; i++) begin
      acc_wr <= 1'b1;
      acc_addr <= {a[7], a[6:0] + 7'(i)};
      acc_wdata <= b[i];
      @(posedge sys_clk);
    end
    acc_wr <= 1'b0;
    acc_wdata <= ~acc_wdata;
    acc_stop <= 1'b1;
    @(posedge sys_clk);
    acc_stop <= 1'b0;
  endtask : wr
endmodule : cmbx_host

// file: tb/test_cmbx_mailbox.sv
`timescale 1ns/1ps
module test_cmbx_mailbox;
  import cmbx_pkg::*;
  typedef struct packed {
    logic [15:0] code;
    logic [7:0]  loc;
    logic        bad;
    logic        split;
    logic [7:0]  rlen;
    logic        fail;
    logic        span;
    logic [7:0]  est;
    logic [7:0]  stat;
  } cmbx_row_t;
  localparam cmbx_row_t ROWS [8] = '{
    '{16'h0040, 8'h00, 1'h0, 1'h0, 8'h00, 1'h0, 1'h0, 8'h00, 8'h01},
    '{16'h0101, 8'h05, 1'h0, 1'h1, 8'h03, 1'h0, 1'h0, 8'h00, 8'h01},
    '{16'h0000, 8'h78, 1'h0, 1'h0, 8'h78, 1'h0, 1'h0, 8'h00, 8'h01},
    '{16'h0041, 8'h02, 1'h1, 1'h0, 8'h02, 1'h0, 1'h0, 8'h00, 8'h45},
    '{16'h0042, 8'h00, 1'h0, 1'h1, 8'h00, 1'h1, 1'h0, 8'h00, 8'h46},
    '{16'h0043, 8'h01, 1'h0, 1'h0, 8'hc8, 1'h0, 1'h0, 8'h00, 8'h47},
    '{16'h0044, 8'h00, 1'h0, 1'h0, 8'hf1, 1'h0, 1'h0, 8'h5a, 8'h01},
    '{16'h0045, 8'h03, 1'h0, 1'h0, 8'hf0, 1'h0, 1'h1, 8'h3c, 8'h01}};
  logic        sys_clk, rst_n, acc_wr, acc_stop, cmd_start, cmd_chk_ok;
  logic        rep_wr, rep_done, rep_fail, rep_span, cmp_clr, cmd_complete;
  logic [7:0]  cur_page, acc_addr, acc_wdata, rd_addr, rd_data, cmd_loc_len;
  logic [7:0]  rep_addr, rep_wdata, rep_len, rep_span_chk, rep_ext_sum;
  logic [7:0]  exec_status;
  logic [15:0] cmd_code, cmd_ext_len;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic        m1_start;
  int          m1_starts = 0;
  cmbx_mailbox dut (.sys_clk(sys_clk), .rst_n(rst_n), .cur_page(cur_page),
    .acc_wr(acc_wr), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_stop(acc_stop), .rd_addr(rd_addr), .rd_data(rd_data),
    .cmd_start(cmd_start), .cmd_code(cmd_code), .cmd_ext_len(cmd_ext_len),
    .cmd_loc_len(cmd_loc_len), .cmd_chk_ok(cmd_chk_ok), .rep_wr(rep_wr),
    .rep_addr(rep_addr), .rep_wdata(rep_wdata), .rep_done(rep_done),
    .rep_fail(rep_fail), .rep_len(rep_len), .rep_span(rep_span),
    .rep_span_chk(rep_span_chk), .rep_ext_sum(rep_ext_sum),
    .cmp_clr(cmp_clr), .exec_status(exec_status),
    .cmd_complete(cmd_complete));
  cmbx_host host (.sys_clk(sys_clk), .cur_page(cur_page), .acc_wr(acc_wr),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_stop(acc_stop));
  // A second copy in trigger mode 1 sees the same traffic as dut.
  cmbx_mailbox #(.TRIGGER_MODE(1'b1)) dut_mode1 (.sys_clk(sys_clk),
    .rst_n(rst_n), .cur_page(cur_page), .acc_wr(acc_wr),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_stop(acc_stop),
    .rd_addr(rd_addr), .rd_data(), .cmd_start(m1_start), .cmd_code(),
    .cmd_ext_len(), .cmd_loc_len(), .cmd_chk_ok(), .rep_wr(rep_wr),
    .rep_addr(rep_addr), .rep_wdata(rep_wdata), .rep_done(rep_done),
    .rep_fail(rep_fail), .rep_len(rep_len), .rep_span(rep_span),
    .rep_span_chk(rep_span_chk), .rep_ext_sum(rep_ext_sum),
    .cmp_clr(cmp_clr), .exec_status(), .cmd_complete());
  // Every start of the mode 1 copy is counted; the pulse lasts one cycle.
  always @(posedge sys_clk) begin
    if (m1_start === 1'b1) begin
      m1_starts <= m1_starts + 1;
    end
  end
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // A hung handshake ends the run here instead of running forever.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_flag
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_addr <= a;
    @(posedge sys_clk);
    #1;
    d = rd_data;
  endtask : rd
  task automatic wait_on(input bit sel, output bit hit);
    hit = 1'b0;
    for (int k = 0; k < 300 && !hit; k++) begin
      @(posedge sys_clk);
      #1;
      hit = sel ? (cmd_complete === 1'b1) : (cmd_start === 1'b1);
    end
  endtask : wait_on
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    cmbx_row_t   r;
    logic [7:0]  q [$];
    logic [7:0]  p [$];
    logic [7:0]  s, x, ck, d;
    logic [15:0] ext;
    bit          hit;
    rst_n = 1'b0;
    {rd_addr, rep_wr, rep_addr, rep_wdata, rep_done, rep_fail} = '0;
    {rep_len, rep_span, rep_span_chk, rep_ext_sum, cmp_clr} = '0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = ROWS[i];
      ext = 16'(i);
      s = r.code[15:8] + r.code[7:0] + ext[15:8] + ext[7:0] + r.loc;
      q = {ext[15:8], ext[7:0], r.loc, 8'h00, 8'hee, 8'hee};
      for (int j = 0; j < r.loc; j++) begin
        q.push_back(8'(j * 7 + 1));
        s += 8'(j * 7 + 1);
      end
      q[3] = ~s ^ {7'h00, r.bad};
      for (int o = 0; o < q.size(); o += 16) begin
        p = {};
        for (int k = o; k < q.size() && k < o + 16; k++) begin
          p.push_back(q[k]);
        end
        host.wr(CMBX_MSG_PAGE, 8'h82 + 8'(o), p);
      end
      if (r.split) begin
        host.wr(CMBX_MSG_PAGE, CMBX_CODE_HI, {r.code[15:8]});
        host.wr(CMBX_MSG_PAGE, CMBX_CODE_LO, {r.code[7:0]});
      end else begin
        host.wr(CMBX_MSG_PAGE, CMBX_CODE_HI, {r.code[15:8], r.code[7:0]});
      end
      wait_on(1'b0, hit);
      chk_flag(hit, 1'b1);
      chk_val(cmd_code, r.code);
      chk_val(cmd_ext_len, ext);
      chk_val(16'(cmd_loc_len), 16'(r.loc));
      chk_flag(cmd_chk_ok, ~r.bad);
      x = 8'h00;
      for (int j = 0; j < r.rlen && r.rlen <= CMBX_LPL_MAX; j++) begin
        @(posedge sys_clk);
        rep_wr <= 1'b1;
        rep_addr <= CMBX_OFS_LPL + 8'(j);
        rep_wdata <= 8'h30 + 8'(j);
        x += 8'h30 + 8'(j);
      end
      @(posedge sys_clk);
      rep_wr <= 1'b0;
      rep_done <= 1'b1;
      rep_len <= r.rlen;
      rep_fail <= r.fail;
      rep_span <= r.span;
      rep_span_chk <= r.est;
      rep_ext_sum <= r.est;
      @(posedge sys_clk);
      rep_done <= 1'b0;
      ck = r.span ? r.est : r.rlen >= CMBX_RPL_EPL_MIN ? ~r.est :
           (r.rlen > CMBX_LPL_MAX || r.rlen == 8'h00) ? 8'h00 : ~x;
      wait_on(1'b1, hit);
      chk_flag(hit, 1'b1);
      chk_val(16'(exec_status), 16'(r.stat));
      rd(CMBX_OFS_RPL_LEN, d);
      chk_val(16'(d), 16'(r.rlen));
      rd(CMBX_OFS_RPL_CHK, d);
      chk_val(16'(d), 16'(ck));
      rd(8'h84, d);
      chk_val(16'(d), 16'(r.loc));
      rd(CMBX_CODE_HI, d);
      chk_val(16'(d), 16'(r.code[15:8]));
      if (r.rlen != 8'h00 && r.rlen <= CMBX_LPL_MAX) begin
        rd(CMBX_OFS_LPL, d);
        chk_val(16'(d), 16'h0030);
      end
      @(posedge sys_clk);
      cmp_clr <= 1'b1;
      @(posedge sys_clk);
      cmp_clr <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk_flag(cmd_complete, 1'b0);
      $display("row %0d done", i);
    end
    host.wr(8'h00, CMBX_CODE_HI, {8'h00, 8'h40});
    wait_on(1'b0, hit);
    chk_flag(hit, 1'b0);
    host.wr(CMBX_MSG_PAGE, CMBX_CODE_HI, {8'h00, 8'h40, 8'h00});
    wait_on(1'b0, hit);
    chk_flag(hit, 1'b0);
    // Mode 1 starts once per row and once more on the three-byte write.
    chk_val(16'(m1_starts), 16'h0009);
    $display("trigger refusals done");
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_val(16'(exec_status), 16'(CMBX_STAT_IDLE));
    chk_flag(cmd_complete, 1'b0);
    chk_flag(cmd_start, 1'b0);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk_val(16'(exec_status), 16'(CMBX_STAT_IDLE));
    chk_flag(cmd_start, 1'b0);
    $display("reset done");
    stop_test();
  end
endmodule : test_cmbx_mailbox
bind cmbx_mailbox cmbx_mailbox_chk chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .cur_page(cur_page), .acc_stop(acc_stop), .rd_data(rd_data),
  .cmd_start(cmd_start), .cmd_chk_ok(cmd_chk_ok), .rep_done(rep_done),
  .cmp_clr(cmp_clr), .exec_status(exec_status),
  .cmd_complete(cmd_complete));
